// *** inc/acc_pkg.sv ***
package acc_pkg;

  // calibration, settling and power-on timing, in mclk periods, modulator periods or samples
  localparam int CAL_OSC_PERIODS = 50;
  localparam int CAL_MOD_PERIODS = 32;
  localparam int CAL_SAMPLES = 16;
  localparam int SETTLE_MOD_PERIODS = 32;
  localparam int POR_CYCLES = 65536;
  // mclk cycles per modulator period
  localparam int MOD_DIV = 16;
  // restoring divider steps, one per dividend bit
  localparam int DIV_STEPS = 45;

  localparam logic [23:0] UNITY_GAIN = 24'h400000;
  localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_SAT = 24'hFFFFFF;
  // full-scale code that a gain calibration aims at
  localparam logic [23:0] FS_TARGET = 24'h7FFFFF;
  // per-gain trimmed defaults, one per amplifier setting
  localparam logic [7:0][23:0] GAIN_TRIM = {8{24'h400000}};

  // byte selects of the correction words, low byte first
  localparam logic [2:0] SEL_OFFSET_LO = 3'h0;
  localparam logic [2:0] SEL_GAIN_LO = 3'h3;

  // reference power select field
  localparam logic [1:0] REF_OFF = 2'h0;
  localparam logic [1:0] REF_ON = 2'h1;
  localparam logic [1:0] REF_AWAKE = 2'h2;

  typedef enum logic [2:0] {
    CMD_SLEEP = 3'h0,
    CMD_WAKE = 3'h1,
    CMD_SYS_GAIN = 3'h2,
    CMD_SYS_OFFSET = 3'h3,
    CMD_SELF_OFFSET = 3'h4
  } acc_cmd_t;

  typedef enum logic [7:0] {
    ST_POR = 8'h01,
    ST_SLEEP = 8'h02,
    ST_SETTLE = 8'h04,
    ST_CONV = 8'h08,
    ST_CAL_OSC = 8'h10,
    ST_CAL_MOD = 8'h20,
    ST_CAL_AVG = 8'h40,
    ST_CAL_DIV = 8'h80
  } acc_state_t;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } acc_sample_t;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [7:0] data;
  } acc_regwr_t;

endpackage

// *** rtl/acc_scaler.sv ***
`timescale 1ns/10ps
module acc_scaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [23:0] raw,
  input wire logic [23:0] offset,
  input wire logic [23:0] gain,
  output logic out_valid,
  output logic [23:0] out_data
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic in_range;
  logic [23:0] clipped;

  assign diff = $signed({raw[23], raw}) - $signed({offset[23], offset});
  assign prod = $signed({{25{diff[24]}}, diff}) * $signed({26'h0, gain});
  // bits 49..45 all equal means the quotient by 2^22 fits 24 bits
  assign in_range = (&prod[49:45]) | ~(|prod[49:45]);
  assign clipped = in_range ? prod[45:22] :
                   (prod[49] ? acc_pkg::CODE_MIN : acc_pkg::CODE_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 24'h000000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= clipped;
      end
    end
  end

  zero_diff_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_valid && raw == offset |=> out_data == 24'h000000)
    else $error("equal input and offset not zero");
  pos_clip_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_valid && raw == acc_pkg::CODE_MAX && offset == acc_pkg::CODE_MIN
    && gain >= acc_pkg::UNITY_GAIN |=> out_data == acc_pkg::CODE_MAX)
    else $error("positive overflow not saturated");
  neg_clip_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_valid && raw == acc_pkg::CODE_MIN && offset == acc_pkg::CODE_MAX
    && gain >= acc_pkg::UNITY_GAIN |=> out_data == acc_pkg::CODE_MIN)
    else $error("negative overflow not saturated");
endmodule

// *** rtl/acc_ctrl.sv ***
`timescale 1ns/10ps
module acc_ctrl #(
  parameter int POR_CYCLES = acc_pkg::POR_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start_pin,
  input wire logic cmd_valid,
  input wire acc_pkg::acc_cmd_t cmd,
  input wire acc_pkg::acc_regwr_t reg_wr,
  input wire logic [2:0] amp_gain_setting,
  input wire logic [1:0] reference_power_select,
  input wire acc_pkg::acc_sample_t filt,
  input wire logic data_read,
  output logic [23:0] offset_correction_word,
  output logic [23:0] gain_correction_word,
  output logic [23:0] result,
  output logic data_out_done_pin,
  output logic filter_reset,
  output logic input_short,
  output logic mod_en,
  output logic ref_power_on,
  output logic analog_power_on,
  output logic ready,
  output logic cal_busy
);
  logic rst_s1;
  logic rst_n;
  logic [16:0] por_cnt;
  logic [3:0] mdiv;
  logic start_q;
  logic start_rise;
  acc_pkg::acc_state_t st;
  acc_pkg::acc_state_t next_st;
  logic [5:0] cnt;
  logic cnt_step;
  logic cnt_clear;
  logic [1:0] cal_kind;
  logic sleep_pend;
  logic signed [27:0] acc;
  logic signed [27:0] sum_in;
  logic [23:0] avg;
  logic signed [24:0] den;
  logic [24:0] rem;
  logic [44:0] quo;
  logic [24:0] rem_sh;
  logic rem_ge;
  logic [44:0] q_fin;
  logic [23:0] gain_cal;
  logic [2:0] gain_prev;
  logic sc_valid;
  logic [23:0] sc_data;

  // command and state decoding
  logic is_cal_cmd;
  logic cal_start;
  logic sleep_cmd;
  logic wake_cmd;
  logic in_cal;
  logic asleep;
  logic last_sample;
  logic off_fin;
  logic gain_fin;
  logic cal_fin;
  logic fin_sleep;
  logic osc_last;
  logic mod_last;
  logic div_last;
  logic gain_change;
  logic wr_offset;
  logic wr_gain;

  localparam logic [1:0] KIND_GAIN = 2'h0;
  localparam logic [1:0] KIND_SYS_OFF = 2'h1;
  localparam logic [1:0] KIND_SELF_OFF = 2'h2;

  // replaces one byte of a correction word
  function automatic logic [23:0] put_byte(input logic [23:0] word,
                                           input logic [1:0] idx,
                                           input logic [7:0] data);
    logic [23:0] w;
    w = word;
    case (idx)
      2'h0: w[7:0] = data;
      2'h1: w[15:8] = data;
      default: w[23:16] = data;
    endcase
    return w;
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // power-on hold; commands and host register writes wait until it ends
  assign ready = por_cnt == 17'(POR_CYCLES);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt <= 17'h00000;
    end else if (!ready) begin
      por_cnt <= por_cnt + 17'h00001;
    end
  end

  assign mod_en = mdiv == 4'(acc_pkg::MOD_DIV - 1);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdiv <= 4'h0;
    end else begin
      mdiv <= mod_en ? 4'h0 : mdiv + 4'h1;
    end
  end

  assign start_rise = start_pin & ~start_q;
  assign is_cal_cmd = cmd_valid & (cmd == acc_pkg::CMD_SYS_GAIN
                      | cmd == acc_pkg::CMD_SYS_OFFSET
                      | cmd == acc_pkg::CMD_SELF_OFFSET);
  assign cal_start = is_cal_cmd & ready;
  assign sleep_cmd = cmd_valid & cmd == acc_pkg::CMD_SLEEP & ready;
  assign wake_cmd = cmd_valid & cmd == acc_pkg::CMD_WAKE & ready;
  assign in_cal = st == acc_pkg::ST_CAL_OSC | st == acc_pkg::ST_CAL_MOD
                  | st == acc_pkg::ST_CAL_AVG | st == acc_pkg::ST_CAL_DIV;
  assign asleep = st == acc_pkg::ST_SLEEP | st == acc_pkg::ST_POR;
  assign osc_last = cnt == 6'(acc_pkg::CAL_OSC_PERIODS - 1);
  assign mod_last = mod_en & cnt == 6'(acc_pkg::CAL_MOD_PERIODS - 1);
  assign div_last = cnt == 6'(acc_pkg::DIV_STEPS - 1);
  assign last_sample = st == acc_pkg::ST_CAL_AVG & filt.valid
                       & cnt == 6'(acc_pkg::CAL_SAMPLES - 1);
  assign off_fin = last_sample & cal_kind != KIND_GAIN;
  assign gain_fin = st == acc_pkg::ST_CAL_DIV & div_last;
  assign cal_fin = (off_fin | gain_fin) & ~cal_start;
  // a sleep request or a lowered start pin takes effect only here
  assign fin_sleep = sleep_pend | ~start_pin;

  always_comb begin
    next_st = st;
    case (st)
      acc_pkg::ST_POR: begin
        if (ready) begin
          next_st = start_pin ? acc_pkg::ST_SETTLE : acc_pkg::ST_SLEEP;
        end
      end
      acc_pkg::ST_SLEEP: begin
        if (start_rise | wake_cmd) begin
          next_st = acc_pkg::ST_SETTLE;
        end
      end
      acc_pkg::ST_SETTLE: begin
        if (sleep_cmd) begin
          next_st = acc_pkg::ST_SLEEP;
        end else if (mod_en
            & cnt == 6'(acc_pkg::SETTLE_MOD_PERIODS - 1)) begin
          next_st = acc_pkg::ST_CONV;
        end
      end
      acc_pkg::ST_CONV: begin
        if (sleep_cmd) begin
          next_st = acc_pkg::ST_SLEEP;
        end else if (start_rise) begin
          next_st = acc_pkg::ST_SETTLE;
        end else if (filt.valid & ~start_pin) begin
          next_st = acc_pkg::ST_SLEEP;
        end
      end
      acc_pkg::ST_CAL_OSC: begin
        if (osc_last) begin
          next_st = acc_pkg::ST_CAL_MOD;
        end
      end
      acc_pkg::ST_CAL_MOD: begin
        if (mod_last) begin
          next_st = acc_pkg::ST_CAL_AVG;
        end
      end
      acc_pkg::ST_CAL_AVG: begin
        if (last_sample) begin
          if (cal_kind == KIND_GAIN) begin
            next_st = acc_pkg::ST_CAL_DIV;
          end else begin
            next_st = fin_sleep ? acc_pkg::ST_SLEEP : acc_pkg::ST_CONV;
          end
        end
      end
      acc_pkg::ST_CAL_DIV: begin
        if (div_last) begin
          next_st = fin_sleep ? acc_pkg::ST_SLEEP : acc_pkg::ST_CONV;
        end
      end
      default: next_st = acc_pkg::ST_POR;
    endcase
    // a calibration command aborts whatever is running
    if (cal_start & st != acc_pkg::ST_POR) begin
      next_st = acc_pkg::ST_CAL_OSC;
    end
  end

  assign cnt_step = (st == acc_pkg::ST_CAL_OSC)
                    | (st == acc_pkg::ST_CAL_DIV)
                    | ((st == acc_pkg::ST_SETTLE | st == acc_pkg::ST_CAL_MOD)
                       & mod_en)
                    | (st == acc_pkg::ST_CAL_AVG & filt.valid);
  assign cnt_clear = (next_st != st) | cal_start | start_rise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= acc_pkg::ST_POR;
      cnt <= 6'h00;
      start_q <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= cnt_clear ? 6'h00 : cnt + {5'h00, cnt_step};
      start_q <= start_pin;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_kind <= KIND_GAIN;
      sleep_pend <= 1'b0;
    end else begin
      if (cal_start) begin
        cal_kind <= cmd == acc_pkg::CMD_SYS_GAIN ? KIND_GAIN :
                    cmd == acc_pkg::CMD_SYS_OFFSET ? KIND_SYS_OFF :
                    KIND_SELF_OFF;
      end
      // a sleep command seen in the finishing cycle sets sleep_pend, too late for fin_sleep to act on it
      sleep_pend <= (in_cal & (sleep_cmd | ~start_pin))
                    | (sleep_pend & ~cal_fin & ~cal_start);
    end
  end

  // sixteen-sample average, divide by 16 as a shift
  assign sum_in = acc + {{4{filt.data[23]}}, filt.data};
  assign avg = sum_in[27:4];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 28'h0000000;
    end else if (st != acc_pkg::ST_CAL_AVG) begin
      acc <= 28'h0000000;
    end else if (filt.valid) begin
      acc <= sum_in;
    end
  end

  // gain = target * 400000h / (average - offset), bit-serial
  assign rem_sh = {rem[23:0], quo[44]};
  assign rem_ge = den > 25'sh0000000 && rem_sh >= den;
  assign q_fin = {quo[43:0], rem_ge};
  assign gain_cal = (den <= 25'sh0000000 || |q_fin[44:24]) ?
                    acc_pkg::GAIN_SAT : q_fin[23:0];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      den <= 25'sh0000000;
      rem <= 25'h0000000;
      quo <= 45'h00000000000;
    end else if (last_sample) begin
      den <= $signed({avg[23], avg})
             - $signed({offset_correction_word[23],
                        offset_correction_word});
      rem <= 25'h0000000;
      quo <= {acc_pkg::FS_TARGET[22:0], 22'h0};
    end else if (st == acc_pkg::ST_CAL_DIV) begin
      rem <= rem_ge ? rem_sh - den : rem_sh;
      quo <= q_fin;
    end
  end

  assign gain_change = gain_prev != amp_gain_setting;
  assign wr_offset = reg_wr.wr & ready
                     & reg_wr.sel < acc_pkg::SEL_GAIN_LO;
  assign wr_gain = reg_wr.wr & ready & reg_wr.sel >= acc_pkg::SEL_GAIN_LO
                   & reg_wr.sel < 3'h6;

  // calibration results win over a host write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      offset_correction_word <= acc_pkg::OFFSET_RESET;
      gain_correction_word <= acc_pkg::GAIN_TRIM[0];
      gain_prev <= 3'h0;
    end else begin
      gain_prev <= amp_gain_setting;
      if (off_fin & ~cal_start) begin
        offset_correction_word <= avg;
      end else if (wr_offset) begin
        offset_correction_word <= put_byte(offset_correction_word,
          2'(reg_wr.sel - acc_pkg::SEL_OFFSET_LO), reg_wr.data);
      end
      if (gain_fin & ~cal_start) begin
        gain_correction_word <= gain_cal;
      end else if (gain_change) begin
        gain_correction_word <= acc_pkg::GAIN_TRIM[amp_gain_setting];
      end else if (wr_gain) begin
        gain_correction_word <= put_byte(gain_correction_word,
          2'(reg_wr.sel - acc_pkg::SEL_GAIN_LO), reg_wr.data);
      end
    end
  end

  acc_scaler u_scaler (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(filt.valid & st == acc_pkg::ST_CONV),
    .raw(filt.data),
    .offset(offset_correction_word),
    .gain(gain_correction_word),
    .out_valid(sc_valid),
    .out_data(sc_data)
  );
  assign result = sc_data;

  // done pin: low on a new result or a finished calibration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_done_pin <= 1'b1;
    end else if (sc_valid | cal_fin) begin
      data_out_done_pin <= 1'b0;
    end else if (data_read | cal_start) begin
      data_out_done_pin <= 1'b1;
    end
  end

  assign filter_reset = st == acc_pkg::ST_POR | st == acc_pkg::ST_SETTLE
                        | st == acc_pkg::ST_CAL_MOD;
  assign input_short = in_cal & cal_kind == KIND_SELF_OFF;
  assign analog_power_on = ~asleep;
  assign ref_power_on = reference_power_select == acc_pkg::REF_ON
                        | (reference_power_select == acc_pkg::REF_AWAKE
                           & ~asleep);
  assign cal_busy = in_cal;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  por_release_a: assert property ($rose(ready) |->
    $past(por_cnt) == 17'(POR_CYCLES - 1) && st == acc_pkg::ST_POR)
    else $error("power-on hold length wrong");
  settle_len_a: assert property (st == acc_pkg::ST_SETTLE
    && next_st == acc_pkg::ST_CONV |-> mod_en && cnt == 6'h1F)
    else $error("filter settle not 32 modulator periods");
  cal_osc_a: assert property (st == acc_pkg::ST_CAL_OSC
    && next_st == acc_pkg::ST_CAL_MOD |-> cnt == 6'h31)
    else $error("oscillator wait not 50 periods");
  cal_avg_a: assert property (st == acc_pkg::ST_CAL_AVG
    && next_st != acc_pkg::ST_CAL_AVG && !cal_start
    |-> filt.valid && cnt == 6'h0F)
    else $error("calibration did not take 16 samples");
  cal_done_a: assert property (cal_fin |=> !data_out_done_pin
    && !in_cal)
    else $error("done not driven low after calibration");
  sleep_wait_a: assert property (in_cal && sleep_cmd && !cal_fin
    |=> sleep_pend && st != acc_pkg::ST_SLEEP)
    else $error("sleep cut a calibration short");
  self_short_a: assert property (cal_start
    && cmd == acc_pkg::CMD_SELF_OFFSET |=> input_short [*2])
    else $error("inputs not shorted for internal offset");
  cal_abort_a: assert property (cal_start && st != acc_pkg::ST_POR
    |=> st == acc_pkg::ST_CAL_OSC && cnt == 6'h00)
    else $error("calibration did not start at once");
  single_shot_a: assert property (st == acc_pkg::ST_CONV
    && filt.valid && !start_pin && !start_rise && !cmd_valid
    |=> st == acc_pkg::ST_SLEEP ##1 !analog_power_on)
    else $error("no shutdown after single conversion");
  gain_reload_a: assert property (gain_change && !gain_fin
    |=> gain_correction_word == acc_pkg::GAIN_TRIM[$past(amp_gain_setting)])
    else $error("gain word not reloaded on gain change");
  ref_sleep_a: assert property (asleep
    && reference_power_select == acc_pkg::REF_AWAKE |-> !ref_power_on)
    else $error("reference left on in sleep");
endmodule

// *** verification/acc_host_model.sv ***
`timescale 1ns/10ps
module acc_host_model (
  input wire logic mclk,
  input wire logic ready,
  input wire logic cal_busy,
  output logic start_pin,
  output logic cmd_valid,
  output acc_pkg::acc_cmd_t cmd,
  output acc_pkg::acc_regwr_t reg_wr,
  output logic data_read
);
  initial begin
    start_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd = acc_pkg::CMD_WAKE;
    reg_wr = '0;
    data_read = 1'b0;
  end
  task automatic pause();
    while (ready !== 1'b1) @(negedge mclk);
  endtask
  task automatic set_start(input logic v);
    @(negedge mclk);
    start_pin = v;
  endtask
  task automatic wr_byte(input logic [2:0] sel, input logic [7:0] d);
    pause();
    // start is raised first, though a shut-down device also takes configuration writes
    if (start_pin !== 1'b1) set_start(1'b1);
    @(negedge mclk);
    reg_wr = '{wr: 1'b1, sel: sel, data: d};
    @(negedge mclk);
    // released lines show junk, not the last value
    reg_wr = '{wr: 1'b0, sel: ~sel, data: ~d};
  endtask
  task automatic send_cmd(input acc_pkg::acc_cmd_t c);
    pause();
    // a running calibration is never interrupted by a command
    while (cal_busy === 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd = acc_pkg::acc_cmd_t'(~c);
  endtask
  task automatic read_out();
    @(negedge mclk);
    data_read = 1'b1;
    @(negedge mclk);
    data_read = 1'b0;
  endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam int POR = 64;
  localparam logic [23:0] TV [3][3] = '{'{24'h123456, 24'h400000, 24'h123456},
    '{24'h800000, 24'h800000, 24'h7FFFFF},
    '{24'h7FFFFF, 24'h400000, 24'h800000}};
  logic mclk = 1'b0;
  logic reset_n;
  logic start_pin, cmd_valid, data_read;
  acc_pkg::acc_cmd_t cmd;
  acc_pkg::acc_regwr_t reg_wr;
  logic [2:0] amp_gain_setting;
  logic [1:0] reference_power_select;
  acc_pkg::acc_sample_t filt;
  logic [23:0] offset_correction_word, gain_correction_word, result;
  logic data_out_done_pin, filter_reset, input_short, mod_en;
  logic ref_power_on, analog_power_on, ready, cal_busy;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] lfsr = 32'hCFE0;
  logic [23:0] m_ofs, m_gain;

  always #20 mclk = ~mclk;

  acc_ctrl #(.POR_CYCLES(POR)) dut (.mclk, .reset_n, .start_pin, .cmd_valid,
    .cmd, .reg_wr, .amp_gain_setting, .reference_power_select, .filt,
    .data_read, .offset_correction_word, .gain_correction_word, .result,
    .data_out_done_pin, .filter_reset, .input_short, .mod_en, .ref_power_on,
    .analog_power_on, .ready, .cal_busy);
  acc_host_model host (.mclk, .ready, .cal_busy, .start_pin, .cmd_valid,
    .cmd, .reg_wr, .data_read);

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic longint sx(input logic [23:0] d);
    return longint'($signed(d));
  endfunction
  function automatic logic [23:0] scale(input logic [23:0] d);
    longint v;
    v = ((sx(d) - sx(m_ofs)) * longint'(m_gain)) >>> 22;
    if (v > 64'sh7FFFFF) return acc_pkg::CODE_MAX;
    if (v < -64'sh800000) return acc_pkg::CODE_MIN;
    return v[23:0];
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_word(input logic [23:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [23:0] d);
    @(negedge mclk);
    filt = '{valid: 1'b1, data: d};
    @(negedge mclk);
    filt = '{valid: 1'b0, data: ~d};
  endtask
  // waits for the filter hold, then counts modulator periods inside it
  task automatic count_hold(input int lim, output int w, output int p);
    w = 0;
    p = 0;
    while (filter_reset !== 1'b1 && w < lim) begin
      @(negedge mclk);
      w++;
    end
    while (filter_reset === 1'b1 && p < 40) begin
      if (mod_en === 1'b1) p++;
      @(negedge mclk);
    end
  endtask
  task automatic conv_check(input logic [23:0] d);
    send(d);
    repeat (3) @(negedge mclk);
    chk_word(result, scale(d), "result");
    chk_flag(data_out_done_pin, 1'b0, "done");
    host.read_out();
    chk_flag(data_out_done_pin, 1'b1, "read");
  endtask
  task automatic set_words(input logic [23:0] o, g);
    for (int i = 0; i < 3; i++) begin
      host.wr_byte(3'(acc_pkg::SEL_OFFSET_LO + i), o[8*i+:8]);
      host.wr_byte(3'(acc_pkg::SEL_GAIN_LO + i), g[8*i+:8]);
    end
    m_ofs = o;
    m_gain = g;
    @(negedge mclk);
    chk_word(offset_correction_word, o, "ofs");
    chk_word(gain_correction_word, g, "gain");
  endtask
  task automatic run_cal(input acc_pkg::acc_cmd_t c, input logic [23:0] base,
                         input logic drop);
    int w, p;
    longint sum, q;
    logic [23:0] v;
    host.set_start(1'b1);
    count_hold(4, w, p);
    host.send_cmd(c);
    chk_flag(cal_busy, 1'b1, "busy");
    chk_flag(input_short, c == acc_pkg::CMD_SELF_OFFSET, "short");
    count_hold(60, w, p);
    chk_flag(w >= 49 && w <= 51 && p == 32, 1'b1, "caltime");
    sum = 0;
    if (drop) host.set_start(1'b0);
    for (int i = 0; i < 16; i++) begin
      v = base + 24'(next_rand() & 32'hF);
      sum += sx(v);
      send(v);
      repeat (3) @(negedge mclk);
    end
    w = 0;
    while (cal_busy === 1'b1 && w < 80) begin
      @(negedge mclk);
      w++;
    end
    @(negedge mclk);
    chk_flag(data_out_done_pin, 1'b0, "caldone");
    if (c == acc_pkg::CMD_SYS_GAIN) begin
      q = sum / 16 - sx(m_ofs);
      q = (q <= 0) ? 64'hFFFFFF : longint'(24'h7FFFFF) * 4194304 / q;
      m_gain = (q > 64'hFFFFFF) ? 24'hFFFFFF : q[23:0];
    end else begin
      m_ofs = 24'(sum / 16);
    end
    chk_word(offset_correction_word, m_ofs, "calofs");
    chk_word(gain_correction_word, m_gain, "calgain");
    if (drop) begin
      chk_flag(analog_power_on, 1'b0, "calsleep");
    end else begin
      host.read_out();
      conv_check(base);
    end
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    int n, p;
    reset_n = 1'b0;
    amp_gain_setting = 3'h0;
    reference_power_select = 2'h1;
    filt = '0;
    @(negedge mclk);
    chk_word(offset_correction_word, acc_pkg::OFFSET_RESET, "ofs0");
    chk_word(gain_correction_word, acc_pkg::GAIN_TRIM[0], "gain0");
    @(negedge mclk);
    reset_n = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk_flag(n >= POR && n <= POR + 4, 1'b1, "por");
    set_words(24'h000010, 24'h300000);
    // any nonzero setting differs from the reset one and forces a reload
    amp_gain_setting = 3'(next_rand()) | 3'h1;
    repeat (2) @(negedge mclk);
    m_gain = acc_pkg::GAIN_TRIM[amp_gain_setting];
    chk_word(gain_correction_word, m_gain, "trim");
    host.set_start(1'b0);
    repeat (3) @(negedge mclk);
    host.set_start(1'b1);
    count_hold(4, n, p);
    chk_flag(p == 32, 1'b1, "settle");
    for (int i = 0; i < 3; i++) begin
      set_words(TV[i][0], TV[i][1]);
      conv_check(TV[i][2]);
    end
    for (int i = 0; i < 4; i++) begin
      set_words(24'(next_rand()), 24'(next_rand() >> 9));
      conv_check(24'(next_rand()));
    end
    host.set_start(1'b0);
    conv_check(24'h012345);
    chk_flag(analog_power_on, 1'b0, "shut");
    send(24'h000777);
    repeat (3) @(negedge mclk);
    chk_flag(data_out_done_pin, 1'b1, "idle");
    for (int s = 0; s < 4; s++) begin
      reference_power_select = 2'(s);
      @(negedge mclk);
      chk_flag(ref_power_on, s == 1, "ref");
    end
    host.set_start(1'b1);
    count_hold(4, n, p);
    chk_flag(analog_power_on, 1'b1, "awake");
    host.send_cmd(acc_pkg::CMD_SLEEP);
    @(negedge mclk);
    chk_flag(analog_power_on, 1'b0, "sleep");
    host.set_start(1'b0);
    run_cal(acc_pkg::CMD_SELF_OFFSET, 24'h001000, 1'b0);
    run_cal(acc_pkg::CMD_SYS_GAIN, 24'h600000, 1'b0);
    run_cal(acc_pkg::CMD_SYS_OFFSET, 24'h000800, 1'b1);
    final_report();
  end
endmodule
